//--- rpc_reset_propagation_control.sv
// Reset propagation controller for a six-link serial switch node.
// Collects local, software, power-state and received-comma reset sources,
// sends comma bursts, drives reset strobes and starts the init flow.
// Assumes all inputs synchronous to sys_clk; comma symbols arrive one per
// pair per enabled cycle; init engines answer with initDone.
`timescale 1ns/1ps

// Overview of operation
// R1: Power-up pin resets chip locally, never sends commas, then runs init flow.
// R2: Global reset trigger resets chip, sends unmaskable comma, then runs init flow.
// R3: Local reset trigger resets chip; with soft-comma flag sends maskable comma first.
// R4: Downstream trigger clears downstream map, sends address comma, keeps control bits.
// R5: D3 to D0 restores standard config and power capability, clears map, sends comma.
// R6: Received address comma on unblocked port restores config and is forwarded; else ignored.
// R7: All sources except the three partial kinds clear all state and buffers.
// R8: Full resets run preload, link sync, identification, credit init; partial ones skip.
// R9: Commas go only on synchronised links; payload-flow permit not needed.
// R10: Received unmaskable comma accepted whatever the block bit (outside the guard), forwarded, guard started, chip reset.
// R11: Maskable comma obeys port block bit 6; blocked ignored, else forwarded and reset.
// R12: Propagating reset sends four consecutive commas on every pair of every synchronised link.
// R13: Sending starts guard timer; received commas are discarded until it expires.
// R14: Incoming reset needs at least four commas in a row on one working pair.
// R15: Each port block bit resets to zero.
// R16: Enumeration sets block bits except root ports; software may change them anytime.
// R17: Guard timer length is a design parameter.
// R18: Simultaneous sources: widest scope wins, only one comma burst sent.
module rpc_reset_propagation_control
   import rpc_pkg::*;
#(
   parameter int NLINK        = NUM_LINKS,
   parameter int NPAIR        = NUM_PAIRS,
   parameter int GUARD_LEN    = GUARD_CYCLES     // see R17
)
(
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        clkEn,
   input  wire logic                        power_up_reset_in_n,
   input  wire logic                        globalResetWr,
   input  wire logic                        localResetWr,
   input  wire logic                        sendSoftCommaWr,
   input  wire logic                        downResetWr,
   input  wire logic                        pmD3ToD0,
   input  wire logic [NLINK-1:0]            linkSynced,
   input  wire logic [NLINK*NPAIR-1:0]      pairWorking,
   input  wire logic [NLINK*NPAIR*2-1:0]    rxComma,
   input  wire logic [NLINK*PORT_CTRL_W-1:0] node_control_register,
   input  wire logic                        initDone,
   output logic [NLINK*NPAIR*2-1:0]         txComma,
   output logic                             chipResetOut,
   output logic                             stdCfgResetOut,
   output logic                             downMapClearOut,
   output logic                             initStartOut,
   output logic                             initBusy,
   output logic                             guardActive
);

   localparam int NP = NLINK * NPAIR;

   // Block bit of one port's control register; its owner clears it on reset,
   // and a clear bit lets any partner reset this node
   function automatic logic blockBit(input logic [NLINK*PORT_CTRL_W-1:0] ctl, input int ln);
      blockBit = ctl[ln*PORT_CTRL_W + BLOCK_BIT_POS];     // see R15
   endfunction

   // Rank of an action, higher means wider scope
   function automatic logic [1:0] commaRank(input rpc_comma_e k);
      case (k)
         RPC_COMMA_UNMSK: commaRank = 2'h3;
         RPC_COMMA_MASK:  commaRank = 2'h2;
         RPC_COMMA_ADDR:  commaRank = 2'h1;
         default:         commaRank = 2'h0;
      endcase
   endfunction

   rpc_state_e               state_ff, nxt_state;
   rpc_action_s              act_ff, nxt_act;
   logic [RUN_CNT_W-1:0]     runCnt_ff [NP];
   logic [RUN_CNT_W-1:0]     nxt_runCnt [NP];
   rpc_comma_e               runKind_ff [NP];
   rpc_comma_e               nxt_runKind [NP];
   logic [RUN_CNT_W-1:0]     sendCnt_ff, nxt_sendCnt;
   logic [GUARD_W-1:0]       guard_ff, nxt_guard;
   logic                     pinSeen_ff, nxt_pinSeen;
   logic [NP*2-1:0]          txComma_ff, nxt_txComma;
   logic                     chipRst_ff, nxt_chipRst;
   logic                     cfgRst_ff, nxt_cfgRst;
   logic                     mapClr_ff, nxt_mapClr;
   logic                     initStart_ff, nxt_initStart;
   rpc_action_s              req;
   logic [NLINK-1:0]         detMask, detUnmsk, detAddr;

   // Comma run detection per pair; a run only counts on a working pair
   always_comb
   begin
      detMask  = '0;
      detUnmsk = '0;
      detAddr  = '0;
      for (int p = 0; p < NP; p++)
      begin
         nxt_runKind[p] = rpc_comma_e'(rxComma[p*2 +: 2]);
         nxt_runCnt[p]  = runCnt_ff[p];
         if (!pairWorking[p] || nxt_runKind[p] == RPC_COMMA_NONE)
            nxt_runCnt[p] = '0;                                    // see R14
         else if (nxt_runKind[p] != runKind_ff[p])
            nxt_runCnt[p] = RUN_CNT_W'(1);
         else if (runCnt_ff[p] < RUN_CNT_W'(COMMA_RUN_MIN))
            nxt_runCnt[p] = runCnt_ff[p] + RUN_CNT_W'(1);
         // Fire once, on the cycle the run reaches four
         if (nxt_runCnt[p] == RUN_CNT_W'(COMMA_RUN_MIN)
             && runCnt_ff[p] != RUN_CNT_W'(COMMA_RUN_MIN) && linkSynced[p/NPAIR])
         begin
            case (nxt_runKind[p])                                  // see R14
               RPC_COMMA_MASK:  detMask[p/NPAIR]  = 1'b1;
               RPC_COMMA_UNMSK: detUnmsk[p/NPAIR] = 1'b1;
               RPC_COMMA_ADDR:  detAddr[p/NPAIR]  = 1'b1;
               default:         ;
            endcase
         end
      end
   end

   // Source arbitration; the widest scope wins so only one burst goes out
   always_comb
   begin
      logic rxUnmsk;
      logic rxMask;
      logic rxAddr;
      rxUnmsk = 1'b0;
      rxMask  = 1'b0;
      rxAddr  = 1'b0;
      req     = '{fullReset: 1'b0, partReset: 1'b0, clrMapOnly: 1'b0,
                  sendKind: RPC_COMMA_NONE};
      if (guard_ff == '0)                                          // see R13
      begin
         for (int l = 0; l < NLINK; l++)
         begin
            rxUnmsk = rxUnmsk | detUnmsk[l];                       // see R10
            rxMask  = rxMask | (detMask[l] & ~blockBit(node_control_register, l)); // see R11
            rxAddr  = rxAddr | (detAddr[l] & ~blockBit(node_control_register, l)); // see R6
         end
      end
      if (globalResetWr || rxUnmsk)                                // see R18
         req = '{fullReset: 1'b1, partReset: 1'b0, clrMapOnly: 1'b0,
                 sendKind: RPC_COMMA_UNMSK};                       // see R2
      else if (rxMask || (localResetWr && sendSoftCommaWr))
         req = '{fullReset: 1'b1, partReset: 1'b0, clrMapOnly: 1'b0,
                 sendKind: RPC_COMMA_MASK};                        // see R3
      else if (localResetWr)
         req = '{fullReset: 1'b1, partReset: 1'b0, clrMapOnly: 1'b0,
                 sendKind: RPC_COMMA_NONE};
      else if (pmD3ToD0 || rxAddr)
         req = '{fullReset: 1'b0, partReset: 1'b1, clrMapOnly: 1'b0,
                 sendKind: RPC_COMMA_ADDR};                        // see R5
      else if (downResetWr)
         req = '{fullReset: 1'b0, partReset: 1'b0, clrMapOnly: 1'b1,
                 sendKind: RPC_COMMA_ADDR};                        // see R4
   end

   // Sequencer: idle, send burst, pulse resets, wait for init flow
   always_comb
   begin
      nxt_state     = state_ff;
      nxt_act       = act_ff;
      nxt_sendCnt   = sendCnt_ff;
      nxt_guard     = (guard_ff != '0) ? guard_ff - GUARD_W'(1) : guard_ff;
      nxt_pinSeen   = 1'b0;
      nxt_txComma   = '0;
      nxt_chipRst   = 1'b0;
      nxt_cfgRst    = 1'b0;
      nxt_mapClr    = 1'b0;
      nxt_initStart = 1'b0;
      case (state_ff)
         RPC_ST_IDLE:
         begin
            if (!power_up_reset_in_n)
            begin
               // Pin reset is local: no commas, init flow follows release
               nxt_pinSeen = 1'b1;                                 // see R1
               nxt_chipRst = 1'b1;
            end
            else if (pinSeen_ff)
            begin
               nxt_state     = RPC_ST_INIT;                        // see R1
               nxt_initStart = 1'b1;
            end
            else if (req.sendKind != RPC_COMMA_NONE)
            begin
               nxt_act     = req;
               nxt_sendCnt = '0;
               nxt_state   = RPC_ST_SEND;
            end
            else if (req.fullReset)
            begin
               nxt_act   = req;
               nxt_state = RPC_ST_RESET;
            end
         end
         RPC_ST_SEND:
         begin
            // Four commas on every pair of every synced link
            for (int p = 0; p < NP; p++)
               if (linkSynced[p/NPAIR])                            // see R9
                  nxt_txComma[p*2 +: 2] = act_ff.sendKind;          // see R12
            nxt_sendCnt = sendCnt_ff + RUN_CNT_W'(1);
            if (sendCnt_ff == RUN_CNT_W'(COMMA_RUN_MIN - 1))
            begin
               nxt_guard = GUARD_W'(GUARD_LEN);                    // see R13
               nxt_state = RPC_ST_RESET;
            end
         end
         RPC_ST_RESET:
         begin
            if (act_ff.fullReset)
            begin
               nxt_chipRst   = 1'b1;                               // see R7
               nxt_initStart = 1'b1;                               // see R8
               nxt_state     = RPC_ST_INIT;
            end
            else
            begin
               // Partial kinds: no state clear, no init flow
               nxt_cfgRst = act_ff.partReset;                      // see R5
               nxt_mapClr = 1'b1;                                  // see R4
               nxt_state  = RPC_ST_IDLE;                           // see R8
            end
         end
         RPC_ST_INIT:
         begin
            if (!power_up_reset_in_n)
               nxt_state = RPC_ST_IDLE;
            else if (initDone)
               nxt_state = RPC_ST_IDLE;
         end
         default:
            nxt_state = RPC_ST_IDLE;
      endcase
      // Pin reset wins in every state: a burst or init flow in flight is cut
      // short, since the pin is local and must never let a comma escape
      if (!power_up_reset_in_n)
      begin
         nxt_state     = RPC_ST_IDLE;
         nxt_pinSeen   = 1'b1;                                     // see R1
         nxt_txComma   = '0;
         nxt_chipRst   = 1'b1;
         nxt_cfgRst    = 1'b0;
         nxt_mapClr    = 1'b0;
         nxt_initStart = 1'b0;
      end
   end

   // Registers; guard timer survives the chip reset it causes on purpose
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff     <= RPC_ST_IDLE;
         act_ff       <= '{fullReset: 1'b0, partReset: 1'b0, clrMapOnly: 1'b0,
                           sendKind: RPC_COMMA_NONE};
         sendCnt_ff   <= '0;
         guard_ff     <= '0;
         pinSeen_ff   <= 1'b0;
         txComma_ff   <= '0;
         chipRst_ff   <= 1'b0;
         cfgRst_ff    <= 1'b0;
         mapClr_ff    <= 1'b0;
         initStart_ff <= 1'b0;
         for (int p = 0; p < NP; p++)
         begin
            runCnt_ff[p]  <= '0;
            runKind_ff[p] <= RPC_COMMA_NONE;
         end
      end
      else if (clkEn)
      begin
         state_ff     <= nxt_state;
         act_ff       <= nxt_act;
         sendCnt_ff   <= nxt_sendCnt;
         guard_ff     <= nxt_guard;
         pinSeen_ff   <= nxt_pinSeen;
         txComma_ff   <= nxt_txComma;
         chipRst_ff   <= nxt_chipRst;
         cfgRst_ff    <= nxt_cfgRst;
         mapClr_ff    <= nxt_mapClr;
         initStart_ff <= nxt_initStart;
         for (int p = 0; p < NP; p++)
         begin
            runCnt_ff[p]  <= nxt_runCnt[p];
            runKind_ff[p] <= nxt_runKind[p];
         end
      end
   end

   // Outputs; block bits themselves live in the port registers (reset 0)
   assign txComma         = txComma_ff;
   assign chipResetOut    = chipRst_ff;
   assign stdCfgResetOut  = cfgRst_ff;
   assign downMapClearOut = mapClr_ff;
   assign initStartOut    = initStart_ff;
   assign initBusy        = (state_ff == RPC_ST_INIT);
   assign guardActive     = (guard_ff != '0);

endmodule // rpc_reset_propagation_control

//--- rpc_pkg.sv
// Package for the reset propagation controller: link count, comma kinds,
// timing constants and the carrier structs shared by the design.
// Assumes a single 50 MHz core clock domain.
package rpc_pkg;

   localparam int          NUM_LINKS      = 6;
   localparam int          NUM_PAIRS      = 4;
   localparam int          COMMA_RUN_MIN  = 4;     // Commas needed to detect or send
   localparam int          RUN_CNT_W      = 3;
   localparam int          BLOCK_BIT_POS  = 6;     // Inbound-reset-block bit in port control
   localparam int          PORT_CTRL_W    = 8;
   localparam int          GUARD_CYCLES   = 65536; // Reset echo guard length, default
   localparam int          GUARD_W        = 32;
   localparam int          STD_CFG_FIRST  = 'h00;  // Standard config range start
   localparam int          STD_CFG_LAST   = 'h3F;  // Standard config range end

   // Comma codes on the per-pair symbol channel
   typedef enum logic [1:0]
   {
      RPC_COMMA_NONE  = 2'h0,
      RPC_COMMA_MASK  = 2'h1,
      RPC_COMMA_UNMSK = 2'h2,
      RPC_COMMA_ADDR  = 2'h3
   } rpc_comma_e;

   // What the winning source asks for
   typedef struct packed
   {
      logic       fullReset;   // Clear all state and buffers, then run init flow
      logic       partReset;   // Restore standard config and clear downstream map
      logic       clrMapOnly;  // Downstream trigger: map only, keep control bits
      rpc_comma_e sendKind;    // Comma to propagate, NONE for none
   } rpc_action_s;

   typedef enum logic [3:0]
   {
      RPC_ST_IDLE  = 4'h1,
      RPC_ST_SEND  = 4'h2,
      RPC_ST_RESET = 4'h4,
      RPC_ST_INIT  = 4'h8
   } rpc_state_e;

endpackage

//--- rpc_reset_propagation_control_asserts.sv
// Checker for the reset propagation controller, bound to its top ports.
// Assumes the single sys_clk domain and the async active-high reset.
`timescale 1ns/1ps
module rpc_reset_propagation_control_asserts
   import rpc_pkg::*;
#(
   parameter int NLINK     = NUM_LINKS,
   parameter int NPAIR     = NUM_PAIRS,
   parameter int GUARD_LEN = GUARD_CYCLES
)
(
   input wire logic                     sys_clk,
   input wire logic                     reset,
   input wire logic                     clkEn,
   input wire logic                     power_up_reset_in_n,
   input wire logic                     globalResetWr,
   input wire logic                     localResetWr,
   input wire logic                     downResetWr,
   input wire logic                     pmD3ToD0,
   input wire logic [NLINK-1:0]         linkSynced,
   input wire logic                     initDone,
   input wire logic [NLINK*NPAIR*2-1:0] txComma,
   input wire logic                     chipResetOut,
   input wire logic                     stdCfgResetOut,
   input wire logic                     downMapClearOut,
   input wire logic                     initStartOut,
   input wire logic                     initBusy,
   input wire logic                     guardActive
);
   logic reqSeen_ff;
   logic nxt_reqSeen;
   logic quiet;

   // A request one edge ago may still be in flight with no output yet
   always_comb
      nxt_reqSeen = clkEn && (globalResetWr || localResetWr || downResetWr || pmD3ToD0);

   always_ff @(posedge sys_clk or posedge reset)
      if (reset)
         reqSeen_ff <= 1'b0;
      else
         reqSeen_ff <= nxt_reqSeen;

   // Approximation of the idle state from the ports alone
   assign quiet = !initBusy && txComma == '0 && !chipResetOut && !stdCfgResetOut
                  && !downMapClearOut && !initStartOut && !reqSeen_ff;

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence burst4;
      (txComma != '0) [*4] ##1 (txComma == '0);
   endsequence

   sequence fullPulse;
      chipResetOut && initStartOut;
   endsequence

   chk_burst_len: assert property ($rose(txComma != '0) |-> burst4)
      else $error("comma burst is not four cycles long");
   chk_global_flow: assert property (
      globalResetWr && clkEn && power_up_reset_in_n && quiet && linkSynced != '0
      |=> ##1 burst4 ##0 fullPulse) else $error("global trigger flow wrong");
   chk_pin_local: assert property (
      !power_up_reset_in_n && clkEn |=> chipResetOut && txComma == '0)
      else $error("pin reset not local");
   chk_pin_release: assert property ($rose(power_up_reset_in_n) |-> ##[1:2] initStartOut)
      else $error("no init after pin release");
   chk_full_init: assert property (
      chipResetOut && power_up_reset_in_n && $past(power_up_reset_in_n) |-> initStartOut)
      else $error("full reset without init start");
   chk_init_busy: assert property (
      initStartOut && !initDone && power_up_reset_in_n |=> initBusy)
      else $error("init start without busy");
   chk_partial_scope: assert property (
      stdCfgResetOut || downMapClearOut |-> !chipResetOut && !initStartOut)
      else $error("partial reset cleared chip");
   chk_cfg_with_map: assert property (stdCfgResetOut |-> downMapClearOut)
      else $error("config restore without map clear");
   chk_guard_start: assert property ($fell(txComma != '0) |-> guardActive)
      else $error("echo guard not running after burst");
endmodule // rpc_reset_propagation_control_asserts

bind rpc_reset_propagation_control rpc_reset_propagation_control_asserts #(
   .NLINK(NLINK), .NPAIR(NPAIR), .GUARD_LEN(GUARD_LEN)
) i_rpc_asserts (
   .sys_clk, .reset, .clkEn, .power_up_reset_in_n, .globalResetWr, .localResetWr,
   .downResetWr, .pmD3ToD0, .linkSynced, .initDone, .txComma, .chipResetOut,
   .stdCfgResetOut, .downMapClearOut, .initStartOut, .initBusy, .guardActive
);

//--- rpc_link_partner.sv
// Far-side link partner: sends a run of one comma code on one pair.
// Assumes the bench pulses sendReq for one cycle while the model is idle.
`timescale 1ns/1ps
module rpc_link_partner
   import rpc_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           reset,
   input  wire logic                           sendReq,
   input  wire logic [4:0]                     sendPair,
   input  wire rpc_comma_e                     sendCode,
   input  wire logic [2:0]                     sendLen,
   output logic [NUM_LINKS*NUM_PAIRS*2-1:0]   rxComma
);
   logic [2:0] left_ff, nxt_left;
   logic [4:0] pair_ff, nxt_pair;
   rpc_comma_e code_ff, nxt_code;

   // Load a run on request, count it down; idle symbols between runs
   always_comb
   begin
      nxt_left = sendReq ? sendLen : (left_ff != 3'h0 ? left_ff - 3'h1 : 3'h0);
      nxt_pair = sendReq ? sendPair : pair_ff;
      nxt_code = sendReq ? sendCode : code_ff;
      rxComma  = '0;
      if (left_ff != 3'h0)
         rxComma[2*pair_ff +: 2] = code_ff;
   end

   always_ff @(posedge sys_clk or posedge reset)
      if (reset)
      begin
         left_ff <= 3'h0;
         pair_ff <= 5'h00;
         code_ff <= RPC_COMMA_NONE;
      end
      else
      begin
         left_ff <= nxt_left;
         pair_ff <= nxt_pair;
         code_ff <= nxt_code;
      end
endmodule // rpc_link_partner

//--- tb.sv
// Testbench for the reset propagation controller: local sources, received
// runs, echo guard and pin reset. Assumes rpc_pkg and the partner model.
`timescale 1ns/1ps
module tb;
   import rpc_pkg::*;
   localparam int W = NUM_LINKS*NUM_PAIRS*2;
   logic         sys_clk = 1'b0;
   logic         reset = 1'b1;
   logic         clkEn = 1'b1;
   logic         power_up_reset_in_n = 1'b1;
   logic         globalResetWr, localResetWr, sendSoftCommaWr, downResetWr, pmD3ToD0;
   logic [5:0]   linkSynced;
   logic [23:0]  pairWorking;
   logic [W-1:0] rxComma, txComma;
   logic [47:0]  node_control_register;
   logic         initDone, sendReq, chipResetOut, stdCfgResetOut, downMapClearOut;
   logic         initStartOut, initBusy, guardActive;
   logic [4:0]   sendPair;
   logic [2:0]   sendLen;
   rpc_comma_e   sendCode;
   logic [31:0]  rnd;
   int           seed, mismatches, samplesChecked, pr;
   // Sources {pm, down, soft, local, global}, comma sent, effect {full, cfg, map}
   logic [4:0]   srcTab [6] = '{5'h01, 5'h02, 5'h06, 5'h08, 5'h10, 5'h0B};
   rpc_comma_e   srcCode [6] = '{RPC_COMMA_UNMSK, RPC_COMMA_NONE, RPC_COMMA_MASK,
                                 RPC_COMMA_ADDR, RPC_COMMA_ADDR, RPC_COMMA_UNMSK};
   logic [2:0]   srcEff [6] = '{3'h4, 3'h4, 3'h4, 3'h1, 3'h3, 3'h4};
   // Received runs: code, {blocked, dead pair}, length, effect (0 means dropped)
   rpc_comma_e   rxCode [7] = '{RPC_COMMA_UNMSK, RPC_COMMA_MASK, RPC_COMMA_MASK,
                                RPC_COMMA_ADDR, RPC_COMMA_ADDR, RPC_COMMA_UNMSK, RPC_COMMA_UNMSK};
   logic [1:0]   rxCond [7] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1};
   logic [2:0]   rxLen [7] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h4};
   logic [2:0]   rxEff [7] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h3, 3'h0, 3'h0};

   rpc_reset_propagation_control #(.GUARD_LEN(20)) i_rpc_reset_propagation_control (
      .sys_clk, .reset, .clkEn, .power_up_reset_in_n, .globalResetWr, .localResetWr,
      .sendSoftCommaWr, .downResetWr, .pmD3ToD0, .linkSynced, .pairWorking, .rxComma,
      .node_control_register, .initDone, .txComma, .chipResetOut, .stdCfgResetOut,
      .downMapClearOut, .initStartOut, .initBusy, .guardActive);
   rpc_link_partner i_rpc_link_partner (.sys_clk, .reset, .sendReq, .sendPair, .sendCode,
      .sendLen, .rxComma);

   // Free-running 50 MHz core clock
   always #10 sys_clk = ~sys_clk;

   // Burst pattern: the code on every pair of every synced link only
   function automatic logic [W-1:0] exp_tx(input rpc_comma_e code);
      logic [W-1:0] v;
      v = '0;
      for (int i = 0; i < NUM_LINKS*NUM_PAIRS; i++)
         if (linkSynced[i/NUM_PAIRS])
            v[2*i +: 2] = code;
      return v;
   endfunction

   task automatic cmp_vec(input logic [W-1:0] got, input logic [W-1:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t comma lines %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      samplesChecked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t strobe %b exp %b", $time, got, exp);
      end
   endtask

   // Inputs change just after the edge so the design samples settled values
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic fire(input logic [4:0] src);
      {pmD3ToD0, downResetWr, sendSoftCommaWr, localResetWr, globalResetWr} = src;
      tick;
      {pmD3ToD0, downResetWr, sendSoftCommaWr, localResetWr, globalResetWr} = 5'h00;
   endtask

   task automatic rx(input logic [4:0] pair, input rpc_comma_e code, input logic [2:0] len);
      sendPair = pair;
      sendCode = code;
      sendLen  = len;
      sendReq  = 1'b1;
      tick;
      sendReq = 1'b0;
   endtask

   // Wait for the first reaction, then check burst, strobes and follow-up
   task automatic expect_rst(input rpc_comma_e code, input logic [2:0] eff);
      int n;
      n = 0;
      while ({txComma, chipResetOut, stdCfgResetOut, downMapClearOut} === '0 && n < 12)
      begin
         tick;
         n++;
      end
      if (code != RPC_COMMA_NONE)
         repeat (4)
         begin
            cmp_vec(txComma, exp_tx(code));
            tick;
         end
      cmp_vec(txComma, '0);
      cmp_bit(chipResetOut, eff[2]);
      cmp_bit(initStartOut, eff[2]);
      cmp_bit(stdCfgResetOut, eff[1]);
      cmp_bit(downMapClearOut, eff[0]);
      if (code != RPC_COMMA_NONE)
         cmp_bit(guardActive, 1'b1);
      tick;
      cmp_bit(initBusy, eff[2]);
   endtask

   task automatic expect_quiet;
      repeat (10)
      begin
         cmp_vec(txComma, '0);
         cmp_bit(chipResetOut | stdCfgResetOut | downMapClearOut, 1'b0);
         tick;
      end
   endtask

   // Finish the init flow and let the echo guard run out
   task automatic settle;
      int n;
      n = 0;
      if (initBusy === 1'b1)
      begin
         initDone = 1'b1;
         tick;
         initDone = 1'b0;
      end
      while ((initBusy | guardActive) !== 1'b0 && n < 60)
      begin
         tick;
         n++;
      end
      cmp_bit(initBusy | guardActive, 1'b0);
   endtask

   task automatic end_sim;
      $display("Mismatches %0d, comparisons %0d", mismatches, samplesChecked);
      if (mismatches == 0 && samplesChecked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog sized well beyond the roughly 340 cycles the tests need
   initial
   begin
      #60000;
      mismatches++;
      end_sim;
   end

   initial
   begin
      seed = 32'h6C44;
      {globalResetWr, localResetWr, sendSoftCommaWr, downResetWr, pmD3ToD0} = 5'h00;
      {initDone, sendReq, sendPair, sendLen} = '0;
      sendCode = RPC_COMMA_NONE;
      {linkSynced, pairWorking, node_control_register} = {6'h3F, 24'hFFFFFF, 48'h0};
      repeat (5) @(posedge sys_clk);
      #1 reset = 1'b0;
      // Pin reset clears locally, sends nothing, starts init once released
      power_up_reset_in_n = 1'b0;
      repeat (3) tick;
      cmp_bit(chipResetOut, 1'b1);
      cmp_vec(txComma, '0);
      power_up_reset_in_n = 1'b1;
      pr = 0;
      repeat (4)
      begin
         tick;
         pr += (initStartOut === 1'b1);
      end
      cmp_bit(pr == 1, 1'b1);
      settle;
      // Every local source, one mixed case, random set of synced links
      for (int k = 0; k < 6; k++)
      begin
         rnd = $random(seed);
         linkSynced = rnd[5:0] | 6'h01;
         fire(srcTab[k]);
         expect_rst(srcCode[k], srcEff[k]);
         settle;
      end
      // Received runs: blocked, unblocked, short and on a dead pair
      for (int k = 0; k < 7; k++)
      begin
         rnd = $random(seed);
         pr = int'(rnd[15:0]) % 24;
         linkSynced = rnd[21:16] | (6'h01 << (pr / 4));
         node_control_register = '0;
         node_control_register[(pr / 4) * 8 + BLOCK_BIT_POS] = rxCond[k][1];
         pairWorking = 24'hFFFFFF;
         pairWorking[pr] = !rxCond[k][0];
         rx(pr[4:0], rxCode[k], rxLen[k]);
         if (rxEff[k] == 3'h0)
            expect_quiet;
         else
            expect_rst(rxCode[k], rxEff[k]);
         settle;
      end
      // Runs inside the echo guard are dropped, accepted once it ends
      {linkSynced, pairWorking, node_control_register} = {6'h3F, 24'hFFFFFF, 48'h0};
      fire(5'h01);
      expect_rst(RPC_COMMA_UNMSK, 3'h4);
      initDone = 1'b1;
      tick;
      initDone = 1'b0;
      rx(5'h00, RPC_COMMA_UNMSK, 3'h4);
      expect_quiet;
      settle;
      rx(5'h00, RPC_COMMA_UNMSK, 3'h4);
      expect_rst(RPC_COMMA_UNMSK, 3'h4);
      settle;
      // A trigger while the enable is low is not taken and leaves no trace
      clkEn = 1'b0;
      fire(5'h01);
      expect_quiet;
      clkEn = 1'b1;
      end_sim;
   end
endmodule // tb
